// ---- btr_top.sv ----
// Branch trace recorder: record stack, trace messages, trace store, freeze.
// Assumes core events arrive as one-cycle pulses on clk_i.
`timescale 1ns/1ps
`default_nettype none
`include "btr_consts.svh"
module btr_top
    import btr_pkg::*;
#(
    parameter int DEPTH       = `BTR_STACK_DEPTH,
    parameter int NGP         = `BTR_GP_COUNTERS,
    parameter int NFIX        = `BTR_FIXED_COUNTERS,
    parameter bit FULL_OPTION = 1'b1,
    parameter bit FSB_PRESENT = 1'b1,
    parameter int STORE_DEPTH = `BTR_STORE_DEPTH,
    parameter int STORE_THR   = `BTR_STORE_THRESHOLD
) (
    input  wire logic                               clk_i,
    input  wire logic                               rst_i,
    // Register port
    input  wire logic [7:0]                         reg_addr_i,
    input  wire logic [63:0]                        reg_wdata_i,
    input  wire logic                               reg_wr_i,
    input  wire logic                               reg_rd_i,
    output logic [63:0]                             reg_rdata_o,
    // Core events
    input  wire logic                               branch_i,
    input  wire btr_kind_e                          kind_i,
    input  wire logic [63:0]                        src_ip_i,
    input  wire logic [63:0]                        dst_ip_i,
    input  wire logic                               coincident_branch_i,
    input  wire logic [63:0]                        coincident_src_i,
    input  wire logic [63:0]                        coincident_dst_i,
    input  wire logic                               debug_exc_i,
    input  wire logic [1:0]                         current_privilege_level_i,
    // Counters
    input  wire logic [NGP-1:0]                     gp_ovf_i,
    input  wire logic [NGP-1:0]                     gp_irq_en_i,
    input  wire logic [NFIX-1:0]                    fix_ovf_i,
    input  wire logic [NFIX*`BTR_FIXED_FIELD_W-1:0] fix_ctrl_i,
    input  wire logic                               sample_thr_i,
    output logic [63:0]                             global_counter_enable_o,
    // System bus trace message
    output logic                                    msg_valid_o,
    output btr_rec_s                                msg_o,
    // Trace store
    output logic                                    store_valid_o,
    output btr_rec_s                                store_rec_o,
    output logic [$clog2(STORE_DEPTH)-1:0]          store_index_o,
    output logic                                    store_irq_o,
    output logic                                    perf_monitor_interrupt_o
);
    localparam int PW = $clog2(DEPTH);
    localparam int SW = $clog2(STORE_DEPTH);

    logic [63:0]   debug_control_r;
    logic [63:0]   global_counter_enable_r;
    logic [SW-1:0] store_index_r;
    logic          store_irq_r;
    logic          store_full_r;
    logic          coinc_pend_r;
    btr_rec_s      coinc_rec_r;
    logic          msg_valid_r;
    btr_rec_s      msg_r;
    logic          store_valid_r;
    btr_rec_s      store_rec_r;
    logic [63:0]   rdata_r;

    logic          rec_en;
    logic          msg_en;
    logic          store_en;
    logic          suppressed;
    logic          ev_take;
    logic          ev_pulse;
    btr_rec_s      ev_rec;
    logic          stack_push;
    logic          perf_monitor_interrupt;
    logic          store_thr;
    logic [PW-1:0] top;
    logic [PW-1:0] rd_idx;
    logic [63:0]   rd_src;
    logic [63:0]   rd_dst;
    logic [63:0]   ctrl_wmask;

    assign rec_en   = debug_control_r[`BTR_BIT_RECORD_EN];
    assign msg_en   = debug_control_r[`BTR_BIT_MSG_EN];
    assign store_en = debug_control_r[`BTR_BIT_STORE_EN];

    // -----------------------------------------------------------------
    // Event sequencing
    // -----------------------------------------------------------------
    // A coincident branch is held and sent one cycle after the interrupt or
    // exception record; a further event in that cycle is served first and the
    // held one waits, so nothing is dropped while events are spaced.
    assign ev_take  = branch_i & ~debug_exc_i;
    assign ev_pulse = ev_take | coinc_pend_r;

    always_comb begin
        ev_rec = coinc_rec_r;
        if (ev_take) begin
            ev_rec.src  = src_ip_i;
            ev_rec.dst  = dst_ip_i;
            ev_rec.kind = kind_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            coinc_pend_r <= 1'b0;
            coinc_rec_r  <= '0;
        end else if (ev_take && coincident_branch_i && kind_i != BTR_EV_BRANCH) begin
            coinc_pend_r     <= 1'b1;
            coinc_rec_r.src  <= coincident_src_i;
            coinc_rec_r.dst  <= coincident_dst_i;
            coinc_rec_r.kind <= BTR_EV_BRANCH;
        end else if (!ev_take) begin
            coinc_pend_r <= 1'b0;
        end
    end

    // Privilege 0 is supervisor, anything above is user
    assign suppressed = (current_privilege_level_i == 2'h0)
                      ? debug_control_r[`BTR_BIT_SUPPR_SUPER]
                      : debug_control_r[`BTR_BIT_SUPPR_USER];

    // Restricted option leaves the stack frozen while messages run
    assign stack_push = ev_pulse
                      & (FULL_OPTION ? (rec_en | msg_en) : (rec_en & ~msg_en));

    // -----------------------------------------------------------------
    // Record stack
    // -----------------------------------------------------------------
    assign rd_idx = reg_addr_i[PW-1:0];

    btr_stack #(
        .DEPTH (DEPTH)
    ) u_stack (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .push_i   (stack_push),
        .rec_i    (ev_rec),
        .rd_idx_i (rd_idx),
        .rd_src_o (rd_src),
        .rd_dst_o (rd_dst),
        .top_o    (top)
    );

    // -----------------------------------------------------------------
    // Trace message and trace store outputs
    // -----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            msg_valid_r <= 1'b0;
            msg_r       <= '0;
        end else begin
            msg_valid_r <= ev_pulse & msg_en & ~suppressed & FSB_PRESENT;
            if (ev_pulse) begin
                msg_r <= ev_rec;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            store_valid_r <= 1'b0;
            store_rec_r   <= '0;
            store_index_r <= '0;
            store_full_r  <= 1'b0;
        end else begin
            store_valid_r <= 1'b0;
            // Rearm first so a record landing in the same cycle wins, unless store_full_r already blocks it
            if (reg_wr_i && reg_addr_i == `BTR_OFF_STATUS) begin
                store_full_r  <= 1'b0;
                store_index_r <= '0;
            end
            if (ev_pulse && store_en && !suppressed && !store_full_r) begin
                store_valid_r <= 1'b1;
                store_rec_r   <= ev_rec;
                if (store_index_r == SW'(STORE_DEPTH - 1)) begin
                    store_index_r <= '0;
                    store_full_r  <= debug_control_r[`BTR_BIT_STORE_IRQ_EN];
                end else begin
                    store_index_r <= store_index_r + 1'b1;
                end
            end
        end
    end

    assign store_thr = store_en & debug_control_r[`BTR_BIT_STORE_IRQ_EN]
                     & (store_index_r >= SW'(STORE_THR) | store_full_r);

    // Threshold interrupt stands until software rearms the store or clears its store or interrupt enable
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            store_irq_r <= 1'b0;
        end else begin
            store_irq_r <= store_thr;
        end
    end

    // -----------------------------------------------------------------
    // Freeze logic
    // -----------------------------------------------------------------
    btr_freeze #(
        .NGP  (NGP),
        .NFIX (NFIX)
    ) u_freeze (
        .gp_ovf_i     (gp_ovf_i),
        .gp_irq_en_i  (gp_irq_en_i),
        .fix_ovf_i    (fix_ovf_i),
        .fix_ctrl_i   (fix_ctrl_i),
        .sample_thr_i (sample_thr_i),
        .store_thr_i  (store_thr & ~store_irq_r),
        .pmi_o        (perf_monitor_interrupt)
    );

    // -----------------------------------------------------------------
    // Debug control and counter enable registers
    // -----------------------------------------------------------------
    // Restricted option refuses both enables together: message wins
    always_comb begin
        ctrl_wmask = reg_wdata_i & `BTR_DEBUG_CONTROL_MASK;
        if (!FULL_OPTION && ctrl_wmask[`BTR_BIT_MSG_EN]) begin
            ctrl_wmask[`BTR_BIT_RECORD_EN] = 1'b0;
        end
    end

    // Hardware clear is applied after the write, so a freeze wins
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            debug_control_r <= `BTR_DEBUG_CONTROL_RST;
        end else begin
            if (reg_wr_i && reg_addr_i == `BTR_OFF_DEBUG_CONTROL) begin
                debug_control_r <= ctrl_wmask;
            end
            if (debug_exc_i ||
                (perf_monitor_interrupt && debug_control_r[`BTR_BIT_FREEZE_REC])) begin
                debug_control_r[`BTR_BIT_RECORD_EN] <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            global_counter_enable_r <= '0;
        end else if (perf_monitor_interrupt && debug_control_r[`BTR_BIT_FREEZE_CNT]) begin
            global_counter_enable_r <= '0;
        end else if (reg_wr_i && reg_addr_i == `BTR_OFF_GLOBAL_CNT_EN) begin
            global_counter_enable_r <= reg_wdata_i;
        end
    end

    // -----------------------------------------------------------------
    // Register read
    // -----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdata_r <= '0;
        end else if (reg_rd_i) begin
            rdata_r <= '0;
            if (reg_addr_i == `BTR_OFF_DEBUG_CONTROL) begin
                rdata_r <= debug_control_r;
            end else if (reg_addr_i == `BTR_OFF_STACK_TOP) begin
                rdata_r <= 64'(top);
            end else if (reg_addr_i == `BTR_OFF_GLOBAL_CNT_EN) begin
                rdata_r <= global_counter_enable_r;
            end else if (reg_addr_i == `BTR_OFF_FEATURE) begin
                rdata_r[`BTR_FEATURE_PRIV_BIT] <= 1'b1;
            end else if (reg_addr_i == `BTR_OFF_STATUS) begin
                rdata_r <= {62'h0, store_full_r, store_irq_r} | (64'(store_index_r) << 8);
            end else if ((reg_addr_i & `BTR_OFF_STACK_MASK) == `BTR_OFF_SRC_BASE
                         && reg_addr_i[5:0] < 6'(DEPTH)) begin
                rdata_r <= rd_src;
            end else if ((reg_addr_i & `BTR_OFF_STACK_MASK) == `BTR_OFF_DST_BASE
                         && reg_addr_i[5:0] < 6'(DEPTH)) begin
                rdata_r <= rd_dst;
            end
        end
    end

    assign reg_rdata_o              = rdata_r;
    assign global_counter_enable_o  = global_counter_enable_r;
    assign msg_valid_o              = msg_valid_r;
    assign msg_o                    = msg_r;
    assign store_valid_o            = store_valid_r;
    assign store_rec_o              = store_rec_r;
    assign store_index_o            = store_index_r;
    assign store_irq_o              = store_irq_r;
    assign perf_monitor_interrupt_o = perf_monitor_interrupt;
endmodule
`default_nettype wire

// ---- btr_consts.svh ----
// Offsets, field positions and counts of the branch trace recorder.
// Assumes inclusion by bare name from package and modules alike.
`ifndef BTR_CONSTS_SVH
`define BTR_CONSTS_SVH

// -----------------------------------------------------------------
// Register offsets (word index)
// -----------------------------------------------------------------
`define BTR_OFF_DEBUG_CONTROL   8'h00
`define BTR_OFF_STACK_TOP       8'h01
`define BTR_OFF_GLOBAL_CNT_EN   8'h02
`define BTR_OFF_FEATURE         8'h03
`define BTR_OFF_STATUS          8'h04
`define BTR_OFF_SRC_BASE        8'h40
`define BTR_OFF_DST_BASE        8'h80
`define BTR_OFF_STACK_MASK      8'hc0

// -----------------------------------------------------------------
// Debug control fields
// -----------------------------------------------------------------
`define BTR_BIT_RECORD_EN       0
`define BTR_BIT_MSG_EN          6
`define BTR_BIT_STORE_EN        7
`define BTR_BIT_STORE_IRQ_EN    8
`define BTR_BIT_SUPPR_SUPER     9
`define BTR_BIT_SUPPR_USER      10
`define BTR_BIT_FREEZE_REC      11
`define BTR_BIT_FREEZE_CNT      12
`define BTR_DEBUG_CONTROL_MASK  64'h0000_0000_0000_1fc1
`define BTR_DEBUG_CONTROL_RST   64'h0
`define BTR_FEATURE_PRIV_BIT    4

// Counter interrupt enables
`define BTR_EVTSEL_IRQ_BIT      20
`define BTR_FIXED_IRQ_BIT       2
`define BTR_FIXED_FIELD_W       4

// -----------------------------------------------------------------
// Sizes
// -----------------------------------------------------------------
`define BTR_STACK_DEPTH         16
`define BTR_GP_COUNTERS         4
`define BTR_FIXED_COUNTERS      3
`define BTR_STORE_DEPTH         64
`define BTR_STORE_THRESHOLD     60

`endif

// ---- btr_pkg.sv ----
// Types shared by the branch trace recorder modules.
// Assumes btr_consts.svh on the include path.
`include "btr_consts.svh"
package btr_pkg;

    typedef enum logic [1:0] {
        BTR_EV_BRANCH    = 2'b00,
        BTR_EV_INTERRUPT = 2'b01,
        BTR_EV_EXCEPTION = 2'b10
    } btr_kind_e;

    typedef struct packed {
        logic [63:0] src;
        logic [63:0] dst;
        btr_kind_e   kind;
    } btr_rec_s;

    typedef struct packed {
        logic [7:0]  addr;
        logic [63:0] wdata;
        logic        wr;
        logic        rd;
    } btr_bus_s;

endpackage

// ---- btr_stack.sv ----
// Circular record stack of source/target address pairs.
// Assumes one push per cycle at most from the recorder.
`timescale 1ns/1ps
`default_nettype none
`include "btr_consts.svh"
module btr_stack
    import btr_pkg::*;
#(
    parameter int DEPTH = `BTR_STACK_DEPTH,
    parameter int PW    = $clog2(DEPTH)
) (
    input  wire logic          clk_i,
    input  wire logic          rst_i,
    input  wire logic          push_i,
    input  wire btr_rec_s      rec_i,
    input  wire logic [PW-1:0] rd_idx_i,
    output logic [63:0]        rd_src_o,
    output logic [63:0]        rd_dst_o,
    output logic [PW-1:0]      top_o
);
    logic [63:0]   src_mem [DEPTH];
    logic [63:0]   dst_mem [DEPTH];
    logic [PW-1:0] top_r;
    logic [PW-1:0] top_nxt;

    assign top_nxt = (top_r == PW'(DEPTH - 1)) ? '0 : top_r + 1'b1;

    // -----------------------------------------------------------------
    // Pointer and entries
    // -----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            top_r <= '0;
        end else if (push_i) begin
            top_r <= top_nxt;
        end
    end

    // Entries keep contents through reset; only pointer is defined
    always_ff @(posedge clk_i) begin
        if (push_i) begin
            src_mem[top_nxt] <= rec_i.src;
            dst_mem[top_nxt] <= rec_i.dst;
        end
    end

    assign rd_src_o = src_mem[rd_idx_i];
    assign rd_dst_o = dst_mem[rd_idx_i];
    assign top_o    = top_r;
endmodule
`default_nettype wire

// ---- btr_freeze.sv ----
// Performance-monitoring interrupt request source and freeze detection.
// Assumes overflow pulses come from counters on the same clock.
`timescale 1ns/1ps
`default_nettype none
`include "btr_consts.svh"
module btr_freeze
    import btr_pkg::*;
#(
    parameter int NGP  = `BTR_GP_COUNTERS,
    parameter int NFIX = `BTR_FIXED_COUNTERS
) (
    input  wire logic [NGP-1:0]                     gp_ovf_i,
    input  wire logic [NGP-1:0]                     gp_irq_en_i,
    input  wire logic [NFIX-1:0]                    fix_ovf_i,
    input  wire logic [NFIX*`BTR_FIXED_FIELD_W-1:0] fix_ctrl_i,
    input  wire logic                               sample_thr_i,
    input  wire logic                               store_thr_i,
    output logic                                    pmi_o
);
    logic [NGP-1:0]  gp_hit;
    logic [NFIX-1:0] fix_hit;

    // -----------------------------------------------------------------
    // Per-counter overflow qualification
    // -----------------------------------------------------------------
    for (genvar g = 0; g < NGP; g++) begin : g_gp
        assign gp_hit[g] = gp_ovf_i[g] & gp_irq_en_i[g];
    end
    for (genvar f = 0; f < NFIX; f++) begin : g_fix
        assign fix_hit[f] = fix_ovf_i[f]
                          & fix_ctrl_i[f*`BTR_FIXED_FIELD_W + `BTR_FIXED_IRQ_BIT];
    end

    assign pmi_o = (|gp_hit) | (|fix_hit) | sample_thr_i | store_thr_i;
endmodule
`default_nettype wire

// ---- btr_props.sv ----
// Port-level checker for the branch trace recorder top.
// Assumes suppress and freeze bits change only by register writes.
`timescale 1ns/1ps
`default_nettype none
module btr_props
    import btr_pkg::*;
#(
    parameter int DEPTH = 16,
    parameter int NGP   = 4
) (
    input wire logic           clk_i,
    input wire logic           rst_i,
    input wire logic [7:0]     reg_addr_i,
    input wire logic [63:0]    reg_wdata_i,
    input wire logic           reg_wr_i,
    input wire logic           reg_rd_i,
    input wire logic [63:0]    reg_rdata_o,
    input wire logic           branch_i,
    input wire btr_kind_e      kind_i,
    input wire logic [63:0]    src_ip_i,
    input wire logic [63:0]    dst_ip_i,
    input wire logic           coincident_branch_i,
    input wire logic [63:0]    coincident_src_i,
    input wire logic           debug_exc_i,
    input wire logic [1:0]     current_privilege_level_i,
    input wire logic [NGP-1:0] gp_ovf_i,
    input wire logic [NGP-1:0] gp_irq_en_i,
    input wire logic           sample_thr_i,
    input wire logic [63:0]    global_counter_enable_o,
    input wire logic           msg_valid_o,
    input wire btr_rec_s       msg_o,
    input wire logic           store_valid_o,
    input wire logic           perf_monitor_interrupt_o
);
    logic [2:0] cfg_r;
    logic       pend_r;
    logic       ev_w;
    logic       supp_w;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Shadow of freeze-counters and both suppress bits
    always_ff @(posedge clk_i) begin
        if (rst_i) cfg_r <= 3'h0;
        else if (reg_wr_i && reg_addr_i == 8'h00) cfg_r <= {reg_wdata_i[12], reg_wdata_i[10:9]};
    end
    // Held branch record still owed after a coincident event
    always_ff @(posedge clk_i) begin
        if (rst_i) pend_r <= 1'b0;
        else pend_r <= branch_i && coincident_branch_i && kind_i != BTR_EV_BRANCH && !debug_exc_i;
    end
    assign ev_w = branch_i && !debug_exc_i;
    assign supp_w = (cfg_r[0] && current_privilege_level_i == 2'h0) ||
                    (cfg_r[1] && current_privilege_level_i != 2'h0);
    property p_no_spur; !ev_w && !pend_r |=> !msg_valid_o && !store_valid_o; endproperty
    a_no_spur: assert property (p_no_spur) else $error("record sent without event");
    property p_msg_data;
        ev_w && !pend_r |=> !msg_valid_o || (msg_o.src == $past(src_ip_i) &&
            msg_o.dst == $past(dst_ip_i) && msg_o.kind == $past(kind_i));
    endproperty
    a_msg_data: assert property (p_msg_data) else $error("message contents wrong");
    property p_coinc;
        (ev_w && coincident_branch_i && kind_i != BTR_EV_BRANCH) ##1 msg_valid_o |=>
            msg_valid_o && msg_o.kind == BTR_EV_BRANCH && msg_o.src == $past(coincident_src_i, 2);
    endproperty
    a_coinc: assert property (p_coinc) else $error("coincident branch message missing");
    property p_priv; ev_w && !pend_r && supp_w |=> !msg_valid_o && !store_valid_o; endproperty
    a_priv: assert property (p_priv) else $error("suppressed level still traced");
    property p_dbg; debug_exc_i && !pend_r |=> !msg_valid_o; endproperty
    a_dbg: assert property (p_dbg) else $error("debug exception was traced");
    property p_top; reg_rd_i && reg_addr_i == 8'h01 |=> reg_rdata_o < 64'(DEPTH); endproperty
    a_top: assert property (p_top) else $error("top pointer out of range");
    property p_feat; reg_rd_i && reg_addr_i == 8'h03 |=> reg_rdata_o[4]; endproperty
    a_feat: assert property (p_feat) else $error("privilege feature bit clear");
    property p_frz; perf_monitor_interrupt_o && cfg_r[2] |=> global_counter_enable_o == 64'h0; endproperty
    a_frz: assert property (p_frz) else $error("counters not frozen");
    property p_pmi_gp; |(gp_ovf_i & gp_irq_en_i) |-> perf_monitor_interrupt_o; endproperty
    a_pmi_gp: assert property (p_pmi_gp) else $error("overflow raised no request");
    property p_pmi_thr; sample_thr_i |-> perf_monitor_interrupt_o; endproperty
    a_pmi_thr: assert property (p_pmi_thr) else $error("threshold raised no request");
endmodule
bind btr_top btr_props #(.DEPTH(DEPTH), .NGP(NGP)) btr_props_inst (.*);
`default_nettype wire

// ---- btr_bus_monitor.sv ----
// Debug monitor on the system bus: counts trace messages, keeps the last.
// Assumes message valid is a one-cycle pulse on clk_i.
`timescale 1ns/1ps
`default_nettype none
module btr_bus_monitor
    import btr_pkg::*;
(
    input  wire logic     clk_i,
    input  wire logic     rst_i,
    input  wire logic     msg_valid_i,
    input  wire btr_rec_s msg_i,
    output logic [15:0]   count_o,
    output btr_rec_s      last_o
);
    always_ff @(posedge clk_i) begin
        if (rst_i) count_o <= 16'h0;
        else if (msg_valid_i) count_o <= count_o + 16'h1;
    end
    always_ff @(posedge clk_i) begin
        if (msg_valid_i) last_o <= msg_i;
    end
endmodule
`default_nettype wire

// ---- test_branch_trace_recorder.sv ----
// Self-checking bench for the branch trace recorder, stack depth 4.
// Assumes the bus monitor model and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module test_branch_trace_recorder
    import btr_pkg::*;
;
    logic        clk_i = 1'b0, rst_i = 1'b1, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
    logic        branch_i = 1'b0, coincident_branch_i = 1'b0, debug_exc_i = 1'b0, sample_thr_i = 1'b0;
    logic [7:0]  reg_addr_i = 8'h00;
    logic [63:0] reg_wdata_i = 64'h0, src_ip_i = 64'h0, dst_ip_i = 64'h0;
    logic [63:0] coincident_src_i = 64'h0, coincident_dst_i = 64'h0;
    btr_kind_e   kind_i = BTR_EV_BRANCH;
    logic [1:0]  current_privilege_level_i = 2'h0;
    logic [3:0]  gp_ovf_i = 4'h0, gp_irq_en_i = 4'h0;
    logic [2:0]  fix_ovf_i = 3'h0, store_index_o;
    logic [11:0] fix_ctrl_i = 12'h000;
    logic [63:0] reg_rdata_o, global_counter_enable_o;
    logic        msg_valid_o, store_valid_o, store_irq_o, perf_monitor_interrupt_o;
    btr_rec_s    msg_o, store_rec_o, mon_last;
    logic [15:0] mon_count;
    int          fail_count = 0;
    int          comparisons = 0;
    logic [63:0] all = '1;
    btr_top #(.DEPTH(4), .STORE_DEPTH(8), .STORE_THR(6)) btr_top_inst (.*);
    btr_bus_monitor btr_bus_monitor_inst (.clk_i, .rst_i, .msg_valid_i(msg_valid_o), .msg_i(msg_o),
        .count_o(mon_count), .last_o(mon_last));
    always #12.5 clk_i = ~clk_i;
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [63:0] d);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge clk_i);
        reg_wr_i <= 1'b0;
    endtask
    // Read data is registered on the strobe edge and holds until the next read
    task automatic rd(input logic [7:0] a, output logic [63:0] d);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge clk_i);
        reg_rd_i <= 1'b0;
        #1 d = reg_rdata_o;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [63:0] m, input logic [63:0] e);
        logic [63:0] d;
        rd(a, d);
        chk(d & m, e);
    endtask
    // One event, then idle cycles for a held coincident record
    task automatic ev(input btr_kind_e k, input logic [63:0] s, input logic c, input logic x);
        @(posedge clk_i);
        branch_i <= 1'b1;
        kind_i <= k;
        src_ip_i <= s;
        dst_ip_i <= ~s;
        coincident_branch_i <= c;
        coincident_src_i <= s + 64'h10;
        coincident_dst_i <= s + 64'h20;
        debug_exc_i <= x;
        @(posedge clk_i);
        branch_i <= 1'b0;
        coincident_branch_i <= 1'b0;
        debug_exc_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        #1;
    endtask
    task automatic t_regs();
        rdchk(8'h00, all, 64'h0);
        rdchk(8'h01, all, 64'h0);
        rdchk(8'h03, 64'h10, 64'h10);
        rdchk(8'h10, all, 64'h0);
        wr(8'h01, 64'h3);
        rdchk(8'h01, all, 64'h0);
    endtask
    task automatic t_msg();
        wr(8'h00, 64'h41);
        for (int i = 0; i < 4; i++) begin
            ev(btr_kind_e'(i % 3), 64'h2000 + 64'(i), 1'b0, 1'b0);
            chk(64'(mon_count), 64'(i + 1));
            chk(64'(mon_last.kind), 64'(i % 3));
        end
        chk(mon_last.dst, ~64'h2003);
        rdchk(8'h01, all, 64'h0);
        rdchk(8'h40, all, 64'h2003);
        rdchk(8'h83, all, ~64'h2002);
    endtask
    task automatic t_coinc();
        ev(BTR_EV_INTERRUPT, 64'h3000, 1'b1, 1'b0);
        chk(64'(mon_count), 64'h6);
        chk(mon_last.src, 64'h3010);
        rdchk(8'h01, all, 64'h2);
    endtask
    task automatic t_priv();
        wr(8'h00, 64'h240);
        ev(BTR_EV_BRANCH, 64'h4000, 1'b0, 1'b0);
        chk(64'(mon_count), 64'h6);
        current_privilege_level_i <= 2'h3;
        ev(BTR_EV_BRANCH, 64'h4100, 1'b0, 1'b0);
        chk(64'(mon_count), 64'h7);
        wr(8'h00, 64'h440);
        ev(BTR_EV_BRANCH, 64'h4200, 1'b0, 1'b0);
        chk(64'(mon_count), 64'h7);
        current_privilege_level_i <= 2'h0;
    endtask
    task automatic t_dbg();
        logic [63:0] t;
        wr(8'h00, 64'h41);
        rd(8'h01, t);
        ev(BTR_EV_BRANCH, 64'h5000, 1'b0, 1'b1);
        chk(64'(mon_count), 64'h7);
        rdchk(8'h00, 64'h1, 64'h0);
        rdchk(8'h01, all, t);
        wr(8'h00, 64'h40);
        ev(BTR_EV_BRANCH, 64'h5100, 1'b0, 1'b0);
        rdchk(8'h01, all, (t + 64'h1) & 64'h3);
    endtask
    task automatic t_freeze();
        wr(8'h02, 64'hff);
        wr(8'h00, 64'h1801);
        @(posedge clk_i);
        gp_ovf_i <= 4'h1;
        gp_irq_en_i <= 4'h1;
        #1 chk(64'(perf_monitor_interrupt_o), 64'h1);
        @(posedge clk_i);
        gp_ovf_i <= 4'h0;
        rdchk(8'h00, 64'h1, 64'h0);
        rdchk(8'h02, all, 64'h0);
        wr(8'h02, 64'hff);
        wr(8'h00, 64'h1801);
        rdchk(8'h02, all, 64'hff);
        @(posedge clk_i);
        fix_ctrl_i <= 12'h008;
        fix_ovf_i <= 3'h1;
        #1 chk(64'(perf_monitor_interrupt_o), 64'h0);
        @(posedge clk_i);
        fix_ctrl_i <= 12'h004;
        #1 chk(64'(perf_monitor_interrupt_o), 64'h1);
        @(posedge clk_i);
        fix_ovf_i <= 3'h0;
        rdchk(8'h02, all, 64'h0);
        wr(8'h02, 64'hff);
        @(posedge clk_i);
        sample_thr_i <= 1'b1;
        @(posedge clk_i);
        sample_thr_i <= 1'b0;
        rdchk(8'h02, all, 64'h0);
    endtask
    task automatic t_store();
        wr(8'h04, 64'h0);
        wr(8'h02, 64'hff);
        wr(8'h00, 64'h1180);
        for (int i = 0; i < 5; i++) ev(BTR_EV_BRANCH, 64'h6000 + 64'(i), 1'b0, 1'b0);
        chk(64'(store_irq_o), 64'h0);
        ev(BTR_EV_BRANCH, 64'h6005, 1'b0, 1'b0);
        chk(64'(store_irq_o), 64'h1);
        rdchk(8'h02, all, 64'h0);
        wr(8'h04, 64'h0);
        wr(8'h00, 64'h80);
        for (int i = 0; i < 9; i++) ev(BTR_EV_BRANCH, 64'h7000 + 64'(i), 1'b0, 1'b0);
        chk(64'(store_irq_o), 64'h0);
        chk(store_rec_o.src, 64'h7008);
        chk(64'(store_index_o), 64'h1);
    endtask
    task automatic print_verdict();
        $display("Mismatches %0d, comparisons %0d", fail_count, comparisons);
        if (fail_count == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial begin
        repeat (4000) @(posedge clk_i);
        fail_count++;
        $display("[FAIL] %0t watchdog expired", $time);
        print_verdict();
    end
    initial begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        t_regs();
        t_msg();
        t_coinc();
        t_priv();
        t_dbg();
        t_freeze();
        t_store();
        print_verdict();
    end
endmodule
`default_nettype wire
